// >>> core/ruc_pkg.sv
// Package for the remote update configuration control block.
// Assumes a single 10 MHz clock domain and synchronous active-high reset.
package ruc_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int PAGE_W  = 8;
  localparam int WDT_W   = 12;
  localparam int CAUSE_W = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [PAGE_W-1:0]  PAGE_RST    = 8'h00;
  localparam logic [WDT_W-1:0]   WDT_TO_RST  = 12'hFFF;
  localparam logic [CAUSE_W-1:0] CAUSE_RST   = 3'h0;

  // ----------------------------------------------------------------------
  // Reconfiguration cause codes, one per source
  // ----------------------------------------------------------------------
  localparam logic [CAUSE_W-1:0] CAUSE_NONE    = 3'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_WDT     = 3'h1;
  localparam logic [CAUSE_W-1:0] CAUSE_CRC     = 3'h2;
  localparam logic [CAUSE_W-1:0] CAUSE_NSTATUS = 3'h3;
  localparam logic [CAUSE_W-1:0] CAUSE_USER    = 3'h4;

  // ----------------------------------------------------------------------
  // Loader states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FLOAD = 3'b000,  // Loading factory image
    ST_FACT  = 3'b001,  // Factory image running
    ST_ALOAD = 3'b010,  // Loading application image
    ST_USER  = 3'b011   // Application in user mode
  } ruc_state_t;

endpackage

// >>> core/ruc_wdog.sv
// User watchdog counter for the remote update control block.
// Assumes enable, restart and timeout come from logic on the same clock.
`timescale 1ns/1ps

module ruc_wdog #(
  parameter int WDT_W = 12
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic [WDT_W-1:0] timeout,
  output logic                  expired
);

  logic [WDT_W-1:0] count_q;

  // ----------------------------------------------------------------------
  // Counter: cleared when stopped or restarted, fires at timeout
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || !run || restart) begin
      count_q <= '0;
    end else if (count_q != timeout) begin
      count_q <= count_q + 1'h1;
    end
  end

  // Expiry pulse in the cycle the count reaches the timeout
  always_ff @(posedge clk) begin
    if (reset || !run || restart) begin
      expired <= 1'h0;
    end else begin
      expired <= (count_q + 1'h1 == timeout) && !expired;
    end
  end

endmodule

// >>> core/ruc_ctrl.sv
// Remote update control: page select, user watchdog and status register.
// Assumes the load engine and user logic share CLK; pin inputs are
// synchronised here.
`timescale 1ns/1ps

// Notes on behaviour
// - In factory mode, loader takes next page from update-control register.
// - In factory mode, loader takes watchdog enable from factory settings.
// - Watchdog timeout comes from factory settings when enabled.
// - Only remote-update-capable application images may restart watchdog.
// - Watchdog expiry records timeout cause, then reloads factory image.
// - Watchdog always disabled while factory image is active.
// - Application load failure records cause, then loads factory image.
// - Successful application load enters user mode.
module ruc_ctrl #(
  parameter int PAGE_W = ruc_pkg::PAGE_W,
  parameter int WDT_W  = ruc_pkg::WDT_W
) (
  input  wire logic                        CLK,
  input  wire logic                        RESET,
  input  wire logic                        CTRL_WR,
  input  wire logic [PAGE_W-1:0]           CTRL_PAGE,
  input  wire logic                        CTRL_WDT_EN,
  input  wire logic [WDT_W-1:0]            CTRL_WDT_TO,
  input  wire logic                        LOAD_START,
  input  wire logic                        LOAD_DONE,
  input  wire logic                        LOAD_ERR_CRC,
  input  wire logic                        LOAD_ERR_STATUS,
  input  wire logic                        IMAGE_RU_CAPABLE,
  input  wire logic                        WDT_RESTART,
  input  wire logic                        USER_RECONFIG,
  output logic                             FACTORY_MODE,
  output logic                             USER_MODE,
  output logic                             LOADING,
  output logic                             LOAD_REQ,
  output logic                             LOAD_FACTORY,
  output logic [PAGE_W-1:0]                LOAD_PAGE,
  output logic                             WDT_ACTIVE,
  output logic [ruc_pkg::CAUSE_W-1:0]      STATUS_CAUSE,
  output logic [PAGE_W-1:0]                STATUS_PAGE
);

  ruc_pkg::ruc_state_t state_q;
  ruc_pkg::ruc_state_t state_d;

  logic [PAGE_W-1:0]           page_q;
  logic                        wdt_en_q;
  logic [WDT_W-1:0]            wdt_to_q;
  logic                        wdt_run;
  logic                        wdt_kick;
  logic                        wdt_expired;
  logic                        err_crc;
  logic                        err_stat;
  logic                        app_fail;
  logic                        to_factory;
  logic [ruc_pkg::CAUSE_W-1:0] cause_d;
  logic                        start_s1_q;
  logic                        start_s2_q;
  logic                        start_s3_q;
  logic                        recfg_s1_q;
  logic                        recfg_s2_q;
  logic                        recfg_s3_q;

  // ----------------------------------------------------------------------
  // Pin synchronisers for start and user reconfiguration request
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      start_s1_q <= 1'h0;
      start_s2_q <= 1'h0;
      start_s3_q <= 1'h0;
      recfg_s1_q <= 1'h0;
      recfg_s2_q <= 1'h0;
      recfg_s3_q <= 1'h0;
    end else begin
      start_s1_q <= LOAD_START;
      start_s2_q <= start_s1_q;
      start_s3_q <= start_s2_q;
      recfg_s1_q <= USER_RECONFIG;
      recfg_s2_q <= recfg_s1_q;
      recfg_s3_q <= recfg_s2_q;
    end
  end

  // ----------------------------------------------------------------------
  // Update-control register, writable only from factory image
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      page_q   <= ruc_pkg::PAGE_RST;
      wdt_en_q <= 1'h0;
      wdt_to_q <= ruc_pkg::WDT_TO_RST;
    end else if (CTRL_WR && state_q == ruc_pkg::ST_FACT) begin
      page_q   <= CTRL_PAGE;
      wdt_en_q <= CTRL_WDT_EN;
      wdt_to_q <= CTRL_WDT_TO;
    end
  end

  // Load error decode, only meaningful for application loads
  assign err_crc  = LOAD_ERR_CRC && state_q == ruc_pkg::ST_ALOAD;
  assign err_stat = LOAD_ERR_STATUS && state_q == ruc_pkg::ST_ALOAD;
  assign app_fail = err_crc || err_stat;

  // Watchdog runs only for applications in user mode
  assign wdt_run  = state_q == ruc_pkg::ST_USER && wdt_en_q;
  assign wdt_kick = WDT_RESTART && IMAGE_RU_CAPABLE;

  ruc_wdog #(
    .WDT_W (WDT_W)
  ) u_wdog (
    .clk     (CLK),
    .reset   (RESET),
    .run     (wdt_run),
    .restart (wdt_kick),
    .timeout (wdt_to_q),
    .expired (wdt_expired)
  );

  assign to_factory = app_fail || (wdt_run && wdt_expired)
                      || (state_q == ruc_pkg::ST_USER && recfg_s2_q
                          && !recfg_s3_q);

  // ----------------------------------------------------------------------
  // Next state of the loader
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ruc_pkg::ST_FLOAD: begin
        if (LOAD_DONE) begin
          state_d = ruc_pkg::ST_FACT;
        end
      end
      ruc_pkg::ST_FACT: begin
        if (start_s2_q && !start_s3_q) begin
          state_d = ruc_pkg::ST_ALOAD;
        end
      end
      ruc_pkg::ST_ALOAD: begin
        if (app_fail) begin
          state_d = ruc_pkg::ST_FLOAD;
        end else if (LOAD_DONE) begin
          state_d = ruc_pkg::ST_USER;
        end
      end
      ruc_pkg::ST_USER: begin
        if (to_factory) begin
          state_d = ruc_pkg::ST_FLOAD;
        end
      end
      default: state_d = ruc_pkg::ST_FLOAD;
    endcase
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q <= ruc_pkg::ST_FLOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // Cause code chosen by source; load errors take priority
  always_comb begin
    cause_d = ruc_pkg::CAUSE_USER;
    if (err_crc) begin
      cause_d = ruc_pkg::CAUSE_CRC;
    end else if (err_stat) begin
      cause_d = ruc_pkg::CAUSE_NSTATUS;
    end else if (wdt_run && wdt_expired) begin
      cause_d = ruc_pkg::CAUSE_WDT;
    end
  end

  // ----------------------------------------------------------------------
  // Status register, written before factory reload
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      STATUS_CAUSE <= ruc_pkg::CAUSE_RST;
      STATUS_PAGE  <= ruc_pkg::PAGE_RST;
    end else if (state_q != ruc_pkg::ST_FLOAD && to_factory) begin
      STATUS_CAUSE <= cause_d;
      STATUS_PAGE  <= page_q;
    end
  end

  // ----------------------------------------------------------------------
  // Registered mode and load outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      FACTORY_MODE <= 1'h0;
      USER_MODE    <= 1'h0;
      LOADING      <= 1'h1;
      LOAD_FACTORY <= 1'h1;
      LOAD_PAGE    <= ruc_pkg::PAGE_RST;
      WDT_ACTIVE   <= 1'h0;
    end else begin
      FACTORY_MODE <= state_d == ruc_pkg::ST_FACT;
      USER_MODE    <= state_d == ruc_pkg::ST_USER;
      LOADING      <= state_d == ruc_pkg::ST_FLOAD
                      || state_d == ruc_pkg::ST_ALOAD;
      LOAD_FACTORY <= state_d != ruc_pkg::ST_ALOAD;
      LOAD_PAGE    <= (state_d == ruc_pkg::ST_ALOAD) ? page_q
                                                     : ruc_pkg::PAGE_RST;
      WDT_ACTIVE   <= state_d == ruc_pkg::ST_USER && wdt_en_q;
    end
  end

  // One-cycle load request on each entry to a loading state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      LOAD_REQ <= 1'h1;
    end else begin
      LOAD_REQ <= state_d != state_q
                  && (state_d == ruc_pkg::ST_FLOAD
                      || state_d == ruc_pkg::ST_ALOAD);
    end
  end

endmodule

// >>> bench/ruc_cfg_mem.sv
// Behavioural configuration memory and load engine.
// Assumes each LOAD_REQ pulse starts one load; dly is at least 1.
`timescale 1ns/1ps

module ruc_cfg_mem (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       req,
  input wire logic       fac,
  input wire logic       bad_crc,
  input wire logic       bad_st,
  input wire logic [3:0] dly,
  output logic           done,
  output logic           crc,
  output logic           st
);
  logic [3:0] cnt_q;
  logic       last;
  // Last cycle of a load that no new request cuts short
  assign last = !reset && !req && cnt_q == 4'h1;
  // Count out a load
  always @(posedge clk) begin
    if (reset) begin
      cnt_q <= 4'h0;
    end else if (req) begin
      cnt_q <= dly;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // Report the outcome for one cycle; factory image always loads
  always @(posedge clk) begin
    done <= last;
    crc  <= last && bad_crc && !fac;
    st   <= last && bad_st && !fac;
  end
endmodule

// >>> bench/ruc_ctrl_assertions.sv
// Port checker for the remote update controller.
// Assumes one clock with synchronous active-high reset.
`timescale 1ns/1ps

module ruc_ctrl_chk (
  input wire logic                       CLK,
  input wire logic                       RESET,
  input wire logic                       CTRL_WR,
  input wire logic [ruc_pkg::PAGE_W-1:0] CTRL_PAGE,
  input wire logic                       LOAD_DONE,
  input wire logic                       LOAD_ERR_CRC,
  input wire logic                       LOAD_ERR_STATUS,
  input wire logic                       FACTORY_MODE,
  input wire logic                       USER_MODE,
  input wire logic                       LOADING,
  input wire logic                       LOAD_REQ,
  input wire logic                       LOAD_FACTORY,
  input wire logic [ruc_pkg::PAGE_W-1:0] LOAD_PAGE,
  input wire logic                       WDT_ACTIVE,
  input wire logic [ruc_pkg::CAUSE_W-1:0] STATUS_CAUSE
);
  logic [ruc_pkg::PAGE_W-1:0] page_q;
  logic                       app_end;
  // Application load reaching its end
  assign app_end = LOADING && !LOAD_FACTORY && LOAD_DONE;
  // Page last accepted in factory mode
  always_ff @(posedge CLK) begin
    if (RESET) page_q <= ruc_pkg::PAGE_RST;
    else if (CTRL_WR && FACTORY_MODE) page_q <= CTRL_PAGE;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_ok; app_end && !LOAD_ERR_CRC && !LOAD_ERR_STATUS; endsequence
  sequence s_crc; app_end && LOAD_ERR_CRC; endsequence
  sequence s_st; app_end && !LOAD_ERR_CRC && LOAD_ERR_STATUS; endsequence
  sequence s_reload; LOADING && LOAD_FACTORY && LOAD_REQ; endsequence
  chk_user_entry: assert property (s_ok |=> USER_MODE && !LOADING)
    else $error("user mode not entered");
  chk_crc_cause: assert property (
    s_crc |=> STATUS_CAUSE == ruc_pkg::CAUSE_CRC ##0 s_reload)
    else $error("crc cause or reload missing");
  chk_stat_cause: assert property (
    s_st |=> STATUS_CAUSE == ruc_pkg::CAUSE_NSTATUS ##0 s_reload)
    else $error("status cause or reload missing");
  chk_load_page: assert property (
    LOADING && !LOAD_FACTORY |-> LOAD_PAGE == page_q)
    else $error("wrong application page");
  chk_wdt_scope: assert property (WDT_ACTIVE |-> USER_MODE)
    else $error("watchdog active outside user mode");
  chk_leave_user: assert property ($fell(USER_MODE) |-> s_reload)
    else $error("no factory reload after user mode");
  chk_app_start: assert property (
    $fell(FACTORY_MODE) |-> LOADING && !LOAD_FACTORY && LOAD_REQ)
    else $error("factory mode left without app load");
  chk_req_pulse: assert property (LOAD_REQ && !RESET |=> !LOAD_REQ)
    else $error("load request longer than a cycle");
endmodule

bind ruc_ctrl ruc_ctrl_chk u_chk (
  .CLK(CLK), .RESET(RESET), .CTRL_WR(CTRL_WR), .CTRL_PAGE(CTRL_PAGE),
  .LOAD_DONE(LOAD_DONE), .LOAD_ERR_CRC(LOAD_ERR_CRC),
  .LOAD_ERR_STATUS(LOAD_ERR_STATUS), .FACTORY_MODE(FACTORY_MODE),
  .USER_MODE(USER_MODE), .LOADING(LOADING), .LOAD_REQ(LOAD_REQ),
  .LOAD_FACTORY(LOAD_FACTORY), .LOAD_PAGE(LOAD_PAGE),
  .WDT_ACTIVE(WDT_ACTIVE), .STATUS_CAUSE(STATUS_CAUSE));

// >>> bench/ruc_ctrl_test.sv
// Self-checking bench for the remote update controller.
// Assumes the memory model answers every load request.
`timescale 1ns/1ps

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end

module remote_update_config_control_test;
  logic CLK = 1'h0, RESET = 1'h1, CTRL_WR = 1'h0, CTRL_WDT_EN = 1'h0;
  logic LOAD_START = 1'h0, IMAGE_RU_CAPABLE = 1'h1, WDT_RESTART = 1'h0;
  logic USER_RECONFIG = 1'h0, bad_crc = 1'h0, bad_st = 1'h0;
  logic LOAD_DONE, LOAD_ERR_CRC, LOAD_ERR_STATUS;
  logic FACTORY_MODE, USER_MODE, LOADING, LOAD_REQ, LOAD_FACTORY, WDT_ACTIVE;
  logic [7:0]  CTRL_PAGE = 8'h00, LOAD_PAGE, STATUS_PAGE;
  logic [11:0] CTRL_WDT_TO = 12'h000;
  logic [2:0]  STATUS_CAUSE;
  logic [3:0]  dly = 4'h1;
  int          n_fail = 0, cmp_count = 0;
  // Rows: crc error, status error, user mode expected, cause expected
  localparam logic [5:0] ROWS [5] = '{{2'h0, 1'h1, ruc_pkg::CAUSE_NONE},
    {2'h2, 1'h0, ruc_pkg::CAUSE_CRC}, {2'h1, 1'h0, ruc_pkg::CAUSE_NSTATUS},
    {2'h3, 1'h0, ruc_pkg::CAUSE_CRC}, {2'h0, 1'h1, ruc_pkg::CAUSE_CRC}};

  ruc_ctrl dut (
    .CLK              (CLK),
    .RESET            (RESET),
    .CTRL_WR          (CTRL_WR),
    .CTRL_PAGE        (CTRL_PAGE),
    .CTRL_WDT_EN      (CTRL_WDT_EN),
    .CTRL_WDT_TO      (CTRL_WDT_TO),
    .LOAD_START       (LOAD_START),
    .LOAD_DONE        (LOAD_DONE),
    .LOAD_ERR_CRC     (LOAD_ERR_CRC),
    .LOAD_ERR_STATUS  (LOAD_ERR_STATUS),
    .IMAGE_RU_CAPABLE (IMAGE_RU_CAPABLE),
    .WDT_RESTART      (WDT_RESTART),
    .USER_RECONFIG    (USER_RECONFIG),
    .FACTORY_MODE     (FACTORY_MODE),
    .USER_MODE        (USER_MODE),
    .LOADING          (LOADING),
    .LOAD_REQ         (LOAD_REQ),
    .LOAD_FACTORY     (LOAD_FACTORY),
    .LOAD_PAGE        (LOAD_PAGE),
    .WDT_ACTIVE       (WDT_ACTIVE),
    .STATUS_CAUSE     (STATUS_CAUSE),
    .STATUS_PAGE      (STATUS_PAGE)
  );
  ruc_cfg_mem mem (.clk(CLK), .reset(RESET), .req(LOAD_REQ),
    .fac(LOAD_FACTORY), .bad_crc(bad_crc), .bad_st(bad_st), .dly(dly),
    .done(LOAD_DONE), .crc(LOAD_ERR_CRC), .st(LOAD_ERR_STATUS));

  initial forever #50 CLK = ~CLK;

  task automatic tick(int n); repeat (n) @(posedge CLK); endtask
  // Bounded wait for factory or user mode
  task automatic wait_mode(bit f);
    int k;
    @(negedge CLK);
    for (k = 0; k < 100 && (f ? FACTORY_MODE : USER_MODE) !== 1'h1; k++)
      @(negedge CLK);
    if (k == 100) n_fail++;
  endtask
  // Factory image writes the update-control settings
  task automatic wr(logic [7:0] p, logic en, logic [11:0] to);
    @(posedge CLK);
    {CTRL_WR, CTRL_PAGE, CTRL_WDT_EN, CTRL_WDT_TO} <= {1'h1, p, en, to};
    @(posedge CLK);
    CTRL_WR <= 1'h0;
  endtask
  // Pulse the load pin or the user reload pin
  task automatic pulse(bit r);
    @(posedge CLK);
    {LOAD_START, USER_RECONFIG} <= r ? 2'h1 : 2'h2;
    tick(3);
    {LOAD_START, USER_RECONFIG} <= 2'h0;
    tick(2);
  endtask
  // Restart the watchdog n times, gap cycles apart
  task automatic kick(int n, int gap);
    repeat (n) begin
      tick(gap);
      WDT_RESTART <= 1'h1;
      tick(1);
      WDT_RESTART <= 1'h0;
    end
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    tick(5);
    RESET <= 1'h0;
    wait_mode(1);
    for (int i = 0; i < 5; i++) begin
      if (USER_MODE) begin
        pulse(1);
        wait_mode(1);
        `CHK(STATUS_CAUSE, ruc_pkg::CAUSE_USER)
      end
      {bad_crc, bad_st} <= ROWS[i][5:4];
      wr(8'(8'h10 + i), 1'h0, 12'h000);
      pulse(0);
      wait_mode(!ROWS[i][3]);
      `CHK(USER_MODE, ROWS[i][3])
      `CHK(STATUS_CAUSE, ROWS[i][2:0])
      if (!ROWS[i][3]) `CHK(STATUS_PAGE, 8'(8'h10 + i))
    end
    // Serviced watchdog survives, then expires once left alone
    pulse(1);
    wait_mode(1);
    dly <= 4'h6;
    wr(8'h5A, 1'h1, 12'h010);
    pulse(0);
    wait_mode(0);
    `CHK(WDT_ACTIVE, 1'h1)
    kick(6, 8);
    tick(13);
    @(negedge CLK);
    `CHK(USER_MODE, 1'h1)
    tick(6);
    @(negedge CLK);
    `CHK(USER_MODE, 1'h0)
    wait_mode(1);
    `CHK(STATUS_CAUSE, ruc_pkg::CAUSE_WDT)
    // Restarts from an image without update support are ignored
    @(posedge CLK);
    IMAGE_RU_CAPABLE <= 1'h0;
    wr(8'h33, 1'h1, 12'h010);
    pulse(0);
    wait_mode(0);
    wr(8'h99, 1'h0, 12'h000);
    kick(6, 3);
    @(negedge CLK);
    `CHK(USER_MODE, 1'h0)
    wait_mode(1);
    @(posedge CLK);
    IMAGE_RU_CAPABLE <= 1'h1;
    pulse(0);
    wait_mode(0);
    `CHK(WDT_ACTIVE, 1'h1)
    pulse(1);
    wait_mode(1);
    `CHK(STATUS_PAGE, 8'h33)
    // Reset in mid-run restarts the factory load
    @(posedge CLK);
    RESET <= 1'h1;
    tick(5);
    @(negedge CLK);
    `CHK({LOADING, LOAD_FACTORY, USER_MODE}, 3'h6)
    `CHK({FACTORY_MODE, WDT_ACTIVE, LOAD_REQ}, 3'h1)
    @(posedge CLK);
    RESET <= 1'h0;
    wait_mode(1);
    `CHK(STATUS_CAUSE, ruc_pkg::CAUSE_RST)
    print_verdict;
  end

  initial begin
    tick(20000);
    n_fail++;
    print_verdict;
  end
endmodule
